/* lpddr2_refresh_and_self_refresh_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lrsr_map.svh"

module lpddr2_refresh_and_self_refresh_tb_top
  import lrsr_pkg::*;
;
  logic                          clock = 1'b0;
  logic                          reset = 1'b1;
  logic                          reset_command = 1'b0;
  logic                          cke;
  logic                          cs_n;
  logic [`LRSR_CA_WIDTH-1:0]     ca;
  logic                          refresh_pulse;
  logic                          refresh_all_banks;
  logic                          refresh_internal;
  logic [2:0]                    refresh_bank;
  logic                          self_refresh_active;
  logic                          power_down_active;
  logic                          exit_busy;
  logic                          internal_clock_on;
  logic [4:0]                    q[$];
  int                            busy_cycles;
  int                            miscompares = 0;
  int                            num_checks = 0;

  always #20 clock = ~clock;

  lrsr_ctrl_model ctrl_u (
    .clock (clock),
    .cke   (cke),
    .cs_n  (cs_n),
    .ca    (ca)
  );

  lrsr_device #(
    .REFI_CYCLES (8)
  ) dut_u (
    .clock               (clock),
    .reset               (reset),
    .cke                 (cke),
    .cs_n                (cs_n),
    .ca                  (ca),
    .reset_command       (reset_command),
    .refresh_pulse       (refresh_pulse),
    .refresh_all_banks   (refresh_all_banks),
    .refresh_internal    (refresh_internal),
    .refresh_bank        (refresh_bank),
    .self_refresh_active (self_refresh_active),
    .power_down_active   (power_down_active),
    .exit_busy           (exit_busy),
    .internal_clock_on   (internal_clock_on)
  );

  // record each refresh as {internal, all, bank}
  always @(posedge clock) begin
    if (refresh_pulse === 1'b1) q.push_back({refresh_internal, refresh_all_banks, refresh_bank});
    if (exit_busy === 1'b1) busy_cycles++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input logic [3:0] exp);
    #1;
    chk({4'h0, self_refresh_active, power_down_active, exit_busy, internal_clock_on}, {4'h0, exp});
  endtask

  task automatic test_per_bank();
    q.delete();
    repeat (9) ctrl_u.refresh(1'b0);
    ctrl_u.refresh(1'b1);
    ctrl_u.refresh(1'b0);
    ctrl_u.wake(5);
    chk(8'(q.size()), 8'd11);
    for (int i = 0; i < 9; i++) chk({3'h0, q[i]}, 8'(i % 8));
    // all-bank pulse shows the counter as it stood: nine per-bank steps leave it at 1
    chk({3'h0, q[9]}, 8'h09);
    chk({3'h0, q[10]}, 8'h00);
    $display("per-bank order test done");
  endtask

  task automatic test_reset_command();
    q.delete();
    ctrl_u.refresh(1'b0);
    ctrl_u.refresh(1'b0);
    ctrl_u.wake(4);
    reset_command <= 1'b1;
    @(posedge clock);
    reset_command <= 1'b0;
    ctrl_u.refresh(1'b0);
    ctrl_u.wake(5);
    chk(8'(q.size()), 8'd3);
    chk({3'h0, q[1]}, 8'h02);
    chk({3'h0, q[2]}, 8'h00);
    chk({3'h0, q[0]}, 8'h01);
    $display("reset command test done");
  endtask

  task automatic test_self_refresh();
    q.delete();
    ctrl_u.self_refresh(30);
    chk_state(4'h8);
    // counter stays at 1, internal refreshes must not move it
    chk(8'(q.size() >= 3), 8'h01);
    foreach (q[i]) chk({3'h0, q[i]}, 8'h19);
    busy_cycles = 0;
    q.delete();
    ctrl_u.wake(8);
    // settle first: the sampler and this task both wake on the last edge
    chk_state(4'h1);
    chk(8'(busy_cycles), 8'(`LRSR_TXSR_CYCLES));
    ctrl_u.refresh(1'b0);
    ctrl_u.wake(5);
    chk({3'h0, q[q.size()-1]}, 8'h00);
    $display("self-refresh test done");
  endtask

  task automatic test_power_down();
    q.delete();
    ctrl_u.drive(1'b0, 1'b1, 4'h0);
    ctrl_u.idle(1'b0, 20);
    chk_state(4'h5);
    ctrl_u.wake(4);
    chk(8'(q.size()), 8'd0);
    chk_state(4'h1);
    $display("power-down test done");
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    ctrl_u.wake(4);
    chk_state(4'h1);
    chk({5'h0, refresh_bank}, 8'h00);
    $display("reset value test done");
    test_per_bank();
    test_reset_command();
    test_self_refresh();
    test_power_down();
    conclude();
  end

  // whole run is about 110 cycles; this is ample margin
  initial begin
    #(5000 * 40);
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire

/* lrsr_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lrsr_map.svh"

module lrsr_ctrl_model (
  // clock
  input  wire logic                      clock,
  // command pins
  output logic                           cke,
  output logic                           cs_n,
  output logic [`LRSR_CA_WIDTH-1:0]      ca
);
  // controller bookkeeping: credits toward the window minimum, spacing against the burst limit
  int cycle    = 0;
  int last_all = -1000;
  int credits  = 0;
  int pb_run   = 0;
  bit owed     = 1'b0;

  always @(posedge clock) cycle <= cycle + 1;

  // clock never stops here, so it is always stable before an exit
  initial begin
    cke  = 1'b1;
    cs_n = 1'b1;
    ca   = 4'h0;
  end

  task automatic drive(input logic k, input logic c, input logic [3:0] a);
    @(posedge clock);
    cke  <= k;
    cs_n <= c;
    ca   <= a;
  endtask

  // nop: select high, address lines toggle so stale values never look valid
  task automatic idle(input logic k, input int n);
    repeat (n) drive(k, 1'b1, ~ca);
  endtask

  // spacing all-bank refreshes wider than an eighth of the burst window keeps any window at eight
  task automatic refresh(input logic all);
    while (all && cycle - last_all <= `LRSR_REFBW_CYCLES / `LRSR_REFBW_MAX) begin
      @(posedge clock);
    end
    drive(1'b1, 1'b0, {all, 3'h4});
    if (all) begin
      last_all = cycle;
      credits++;
      pb_run = 0;
      owed = 1'b0;
    end else begin
      pb_run++;
      if (pb_run == `LRSR_BANKS) begin
        credits++;
        pb_run = 0;
        owed = 1'b0;
      end
    end
  endtask

  // caller keeps banks idle; an all-bank refresh goes out first if no full refresh round followed the last entry
  task automatic self_refresh(input int n);
    if (owed) begin
      refresh(1'b1);
    end
    drive(1'b0, 1'b0, 4'h4);
    drive(1'b0, 1'b1, 4'h7);
    idle(1'b0, n);
    // residency lowers the count still owed in this window, one per whole interval plus one
    credits += (n + `LRSR_TREFI_CYCLES) / `LRSR_TREFI_CYCLES;
    pb_run = 0;
    owed = 1'b1;
  endtask

  task automatic wake(input int n);
    idle(1'b1, n);
  endtask
endmodule

`default_nettype wire

/* lrsr_device.sv */
// Behaviour
// - Self-refresh entry: clock enable falls, select low, command bits 0,0,1.
// - In self-refresh only clock enable matters; clock gated, own timer refreshes.
// - An internal all-bank refresh starts soon after self-refresh entry.
// - Exit delay counts from the edge after clock enable goes high.
// - No refresh happens during power-down; controller bounds its length.
// - Refresh decode: select low, bits 0,0,1; bit 3 picks all-bank.
// - Per-bank order 0..7; counter zeroed on reset command and self-refresh exit.
`timescale 1ns/100ps
`default_nettype none
`include "lrsr_map.svh"

module lrsr_device
  import lrsr_pkg::*;
#(
  parameter int BANKS       = `LRSR_BANKS,
  parameter int XSR_CYCLES  = `LRSR_TXSR_CYCLES,
  parameter int REFI_CYCLES = `LRSR_TREFI_CYCLES
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // command pins from the controller
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic [`LRSR_CA_WIDTH-1:0]  ca,
  // reset command decoded elsewhere on this clock
  input  wire logic                       reset_command,
  // refresh activity
  output logic                            refresh_pulse,
  output logic                            refresh_all_banks,
  output logic                            refresh_internal,
  output logic [$clog2(BANKS)-1:0]        refresh_bank,
  // power state
  output logic                            self_refresh_active,
  output logic                            power_down_active,
  output logic                            exit_busy,
  output logic                            internal_clock_on
);
  localparam int PW = `LRSR_CA_WIDTH + 2;
  localparam int XW = $clog2(XSR_CYCLES + 1);

  lrsr_state_type state;
  lrsr_state_type next_state;

  logic [PW-1:0]             pin_meta;
  logic [PW-1:0]             pin_sync;
  logic                      cke_s;
  logic                      cs_n_s;
  logic [`LRSR_CA_WIDTH-1:0] ca_s;
  logic                      prev_cke;
  logic [XW-1:0]             exit_count;
  logic                      pattern;
  logic                      ext_req;
  logic                      sr_exit_reg;

  lrsr_refresh_if #(.BANK_WIDTH($clog2(BANKS))) rif ();

  function automatic logic is_refresh_code(input logic sel_n, input logic [`LRSR_CA_WIDTH-1:0] bits);
    is_refresh_code = !sel_n && (bits[`LRSR_CA_OP_MSB:0] == `LRSR_CA_REFRESH);
  endfunction

  // pins arrive from outside this clock: two flops before any use
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta <= {1'b0, 1'b1, `LRSR_CA_WIDTH'('0)};
      pin_sync <= {1'b0, 1'b1, `LRSR_CA_WIDTH'('0)};
    end else begin
      pin_meta <= {cke, cs_n, ca};
      pin_sync <= pin_meta;
    end
  end

  assign cke_s   = pin_sync[PW-1];
  assign cs_n_s  = pin_sync[PW-2];
  assign ca_s    = pin_sync[`LRSR_CA_WIDTH-1:0];
  assign pattern = is_refresh_code(cs_n_s, ca_s);

  always_ff @(posedge clock) begin
    if (reset) begin
      prev_cke <= 1'b0;
    end else begin
      prev_cke <= cke_s;
    end
  end

  always_comb begin
    next_state  = state;
    ext_req     = 1'b0;
    sr_exit_reg = 1'b0;
    unique case (state)
      lrsr_run: begin
        if (prev_cke && cke_s && pattern) begin
          ext_req = 1'b1;
        end
        if (prev_cke && !cke_s) begin
          next_state = pattern ? lrsr_self_refresh : lrsr_power_down;
        end
      end
      lrsr_power_down: begin
        // no refresh work at all here, controller must bound the stay
        if (cke_s) begin
          next_state = lrsr_run;
        end
      end
      lrsr_self_refresh: begin
        // every input but clock enable is a don't-care here
        if (cke_s) begin
          next_state  = lrsr_exit;
          sr_exit_reg = 1'b1;
        end
      end
      lrsr_exit: begin
        // commands ignored until the exit delay ends; re-entry allowed
        if (!cke_s && pattern) begin
          next_state = lrsr_self_refresh;
        end else if (exit_count == '0) begin
          next_state = lrsr_run;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= lrsr_run;
    end else begin
      state <= next_state;
    end
  end

  // exit delay starts at the edge after clock enable was seen high
  always_ff @(posedge clock) begin
    if (reset) begin
      exit_count <= '0;
    end else if (sr_exit_reg) begin
      exit_count <= XW'(XSR_CYCLES - 1);
    end else if (state == lrsr_exit && exit_count != '0) begin
      exit_count <= XW'(exit_count - 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      self_refresh_active <= 1'b0;
      power_down_active   <= 1'b0;
      exit_busy           <= 1'b0;
      internal_clock_on   <= 1'b1;
    end else begin
      self_refresh_active <= next_state == lrsr_self_refresh;
      power_down_active   <= next_state == lrsr_power_down;
      exit_busy           <= next_state == lrsr_exit;
      internal_clock_on   <= next_state != lrsr_self_refresh;
    end
  end

  assign rif.ext_req   = ext_req;
  assign rif.ext_all   = ca_s[`LRSR_CA_ALLBANK_BIT];
  assign rif.sr_active = state == lrsr_self_refresh;
  assign rif.sync_zero = sr_exit_reg || reset_command;

  lrsr_refresh_engine #(
    .BANKS       (BANKS),
    .REFI_CYCLES (REFI_CYCLES)
  ) engine (
    .clock (clock),
    .reset (reset),
    .rif   (rif.engine)
  );

  assign refresh_pulse     = rif.refresh_pulse;
  assign refresh_all_banks = rif.refresh_all;
  assign refresh_internal  = rif.refresh_internal;
  assign refresh_bank      = rif.refresh_bank;

  sequence sr_entry_seen;
    state == lrsr_run && prev_cke && !cke_s && pattern;
  endsequence

  sequence sr_exit_seen;
    state == lrsr_self_refresh && cke_s;
  endsequence

  sr_entry_a: assert property (@(posedge clock) disable iff (reset)
    sr_entry_seen |=> self_refresh_active && !internal_clock_on && !power_down_active)
    else $error("self-refresh entry not taken");

  sr_hold_a: assert property (@(posedge clock) disable iff (reset)
    (state == lrsr_self_refresh && !cke_s) |=> state == lrsr_self_refresh && !ext_req)
    else $error("self-refresh left or command taken while clock enable low");

  first_refresh_a: assert property (@(posedge clock) disable iff (reset)
    $rose(self_refresh_active) |-> ##[1:2] (refresh_internal && refresh_all_banks))
    else $error("no internal refresh after self-refresh entry");

  exit_delay_a: assert property (@(posedge clock) disable iff (reset)
    sr_exit_seen ##1 cke_s[*4] |-> exit_busy ##1 (!exit_busy && state == lrsr_run))
    else $error("exit delay length wrong");

  exit_ignore_a: assert property (@(posedge clock) disable iff (reset)
    exit_busy |-> !ext_req ##1 !(refresh_pulse && !refresh_internal))
    else $error("command accepted during exit delay");

  pd_quiet_a: assert property (@(posedge clock) disable iff (reset)
    (power_down_active && state == lrsr_power_down) |-> ##1 !refresh_pulse)
    else $error("refresh during power-down");

  refresh_take_a: assert property (@(posedge clock) disable iff (reset)
    ext_req |=> refresh_pulse && !refresh_internal
               && refresh_all_banks == $past(ca_s[`LRSR_CA_ALLBANK_BIT]))
    else $error("refresh command decode wrong");

  exit_sync_a: assert property (@(posedge clock) disable iff (reset)
    sr_exit_seen |-> rif.sync_zero)
    else $error("bank counter not synced at self-refresh exit");

endmodule

`default_nettype wire

/* lrsr_map.svh */
`ifndef LRSR_MAP_SVH
`define LRSR_MAP_SVH

// clock period of the device clock
`define LRSR_CLOCK_NS        40
// self-refresh exit delay, least time
`define LRSR_TXSR_NS         140
`define LRSR_TXSR_CYCLES     ((`LRSR_TXSR_NS + `LRSR_CLOCK_NS - 1) / `LRSR_CLOCK_NS)
// internal refresh interval used while in self-refresh, longest time
`define LRSR_TREFI_NS        3900
`define LRSR_TREFI_CYCLES    (`LRSR_TREFI_NS / `LRSR_CLOCK_NS)

// command field positions and codes on the command/address pins
`define LRSR_CA_OP_MSB       2
`define LRSR_CA_REFRESH      3'h4
`define LRSR_CA_ALLBANK_BIT  3
`define LRSR_CA_WIDTH        4

// banks walked by per-bank refresh
`define LRSR_BANKS           8

// all-bank refresh cycle time in clocks, plain default
`define LRSR_TRFCAB_CYCLES   8
// burst window of 4 x 8 all-bank cycle times, and the all-bank count allowed in it
`define LRSR_REFBW_CYCLES    (4 * 8 * `LRSR_TRFCAB_CYCLES)
`define LRSR_REFBW_MAX       8

`endif

/* lrsr_pkg.sv */
package lrsr_pkg;

  typedef enum logic [1:0] {
    lrsr_run,
    lrsr_power_down,
    lrsr_self_refresh,
    lrsr_exit
  } lrsr_state_type;

endpackage

/* lrsr_refresh_engine.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lrsr_map.svh"

module lrsr_refresh_engine
  import lrsr_pkg::*;
#(
  parameter int BANKS       = `LRSR_BANKS,
  parameter int REFI_CYCLES = `LRSR_TREFI_CYCLES
) (
  // clock and reset
  input  wire logic     clock,
  input  wire logic     reset,
  // command side
  lrsr_refresh_if.engine rif
);
  localparam int BW = $clog2(BANKS);
  localparam int TW = $clog2(REFI_CYCLES + 1);

  logic [BW-1:0] bank_count;
  logic [TW-1:0] timer;
  logic          timer_fire;

  assign timer_fire = rif.sr_active && (timer == '0);

  // bank counter: zeroed on sync or all-bank refresh, walks 0..7 on per-bank
  always_ff @(posedge clock) begin
    if (reset || rif.sync_zero) begin
      bank_count <= '0;
    end else if (rif.ext_req && rif.ext_all) begin
      bank_count <= '0;
    end else if (rif.ext_req) begin
      bank_count <= BW'(bank_count + 1'b1);
    end
  end

  // own timer keeps data alive with the outside clock gone;
  // fires on the first self-refresh cycle so the first refresh is early
  always_ff @(posedge clock) begin
    if (reset || !rif.sr_active) begin
      timer <= '0;
    end else if (timer_fire) begin
      timer <= TW'(REFI_CYCLES - 1);
    end else begin
      timer <= TW'(timer - 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rif.refresh_pulse    <= 1'b0;
      rif.refresh_all      <= 1'b0;
      rif.refresh_internal <= 1'b0;
      rif.refresh_bank     <= '0;
    end else begin
      rif.refresh_pulse    <= rif.ext_req || timer_fire;
      rif.refresh_all      <= timer_fire || rif.ext_all;
      rif.refresh_internal <= timer_fire;
      rif.refresh_bank     <= bank_count;
    end
  end

  bank_walk_a: assert property (@(posedge clock) disable iff (reset)
    (rif.ext_req && !rif.ext_all && !rif.sync_zero)
      |=> rif.refresh_pulse && !rif.refresh_all && rif.refresh_bank == $past(bank_count)
          && bank_count == BW'($past(bank_count) + 1'b1))
    else $error("per-bank refresh did not take and advance the bank counter");

  bank_sync_a: assert property (@(posedge clock) disable iff (reset)
    rif.sync_zero |=> bank_count == '0)
    else $error("bank counter not zeroed on sync");

endmodule

`default_nettype wire

/* lrsr_refresh_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface lrsr_refresh_if #(
  parameter int BANK_WIDTH = 3
);
  logic                  ext_req;
  logic                  ext_all;
  logic                  sr_active;
  logic                  sync_zero;
  logic                  refresh_pulse;
  logic                  refresh_all;
  logic                  refresh_internal;
  logic [BANK_WIDTH-1:0] refresh_bank;

  modport command (
    output ext_req,
    output ext_all,
    output sr_active,
    output sync_zero,
    input  refresh_pulse,
    input  refresh_all,
    input  refresh_internal,
    input  refresh_bank
  );

  modport engine (
    input  ext_req,
    input  ext_all,
    input  sr_active,
    input  sync_zero,
    output refresh_pulse,
    output refresh_all,
    output refresh_internal,
    output refresh_bank
  );
endinterface

`default_nettype wire
